/* File: pac_defs.vh */
`ifndef PAC_DEFS_VH
`define PAC_DEFS_VH

// Register addresses of the bank
`define PAC_ADDR_W          16
`define PAC_ADDR_FILT       16'h00B0
`define PAC_ADDR_MODE       16'h00B1
`define PAC_ADDR_OSCA       16'h00B2
`define PAC_ADDR_OSCB       16'h00B3

// Field positions in loop_filter_pump_cfg
`define PAC_PUMP_MSB        7
`define PAC_PUMP_LSB        5
`define PAC_RES_MSB         4
`define PAC_RES_LSB         3
`define PAC_CAP_MSB         2
`define PAC_CAP_LSB         1
`define PAC_POLE_BIT        0

// Field positions in loop_mode_lock_cfg
`define PAC_SYN_BIT         3
`define PAC_LCNT_BIT        1
`define PAC_OVR_BIT         0

// Field positions in manual_osc_a_cfg; the lock code field also in manual_osc_b_cfg
`define PAC_CHOICE_BIT      5
`define PAC_LOCK_MSB        4
`define PAC_LOCK_LSB        0

// Field widths
`define PAC_PUMP_W          3
`define PAC_RES_W           2
`define PAC_CAP_W           2
`define PAC_LOCK_W          5

// Field reset values
`define PAC_PUMP_RST        3'h4
`define PAC_RES_RST         2'h1
`define PAC_CAP_RST         2'h1
`define PAC_POLE_RST        1'h1
`define PAC_LCNT_RST        1'h1
`define PAC_OVR_RST         1'h0
`define PAC_CHOICE_RST      1'h1
`define PAC_OSCA_RST        5'h0B
`define PAC_OSCB_RST        5'h00
`define PAC_SYN_RST         1'h0

// Reserved bit masks per register
`define PAC_RSVD_FILT       8'h00
`define PAC_RSVD_MODE       8'hF4
`define PAC_RSVD_OSCA       8'hC0
`define PAC_RSVD_OSCB       8'hE0

// Decoded reset values
`define PAC_PUMP_OH_RST     8'h10
`define PAC_RES_OH_RST      4'h2
`define PAC_CAP_OH_RST      4'h2
`define PAC_ONE8            8'h01
`define PAC_ONE4            4'h1
`define PAC_ZERO8           8'h00

`endif

/* File: pac_field.v */
`timescale 1ns/1ps
`default_nettype none

// One read/write configuration field with its own reset value
module pac_field #(
  parameter            W   = 1,
  parameter [W-1:0]    RST = {W{1'h0}}
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          wrEn,
  input  wire [W-1:0]  wrData,
  output reg  [W-1:0]  value_q
);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= RST;
    end else if (wrEn) begin
      value_q <= wrData;
    end
  end

endmodule // pac_field

`default_nettype wire

/* File: pac_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "pac_defs.vh"

// How it works
// - Pump current code resets to 100; codes 000..111 give eight rising steps.
// - Series resistor code resets to 01; four values rising with the code.
// - Parallel capacitor code resets to 01; four values rising with the code.
// - Second pole bit resets to 1, larger resistor; 0 gives the smaller one.
// - Lock count accuracy bit resets to 1, coarse; 0 selects fine accuracy.
// - Lock override resets to 0, automatic; 1 selects manual lock control.
// - Manual oscillator choice: 1 first oscillator (reset), 0 second oscillator.
// - First oscillator manual lock code is 5 bits, resetting to 01011.
// - Second oscillator manual lock code is 5 bits, resetting to zero.
// - Synth only bit resets to 0, translating; 1 synthesizes from crystal only.
// - Reserved bits are written zero; this bank reads them back as zero.
module pac_regs (
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire [`PAC_ADDR_W-1:0]   regAddr,
  input  wire                     regWrEn,
  input  wire [7:0]               regWrData,
  input  wire                     regRdEn,
  input  wire                     rsvdErrClr,
  output reg  [7:0]               regRdData_q,
  output reg                      regRdValid_q,
  output reg                      regHit_q,
  output reg                      rsvdErr_q,
  output wire [`PAC_PUMP_W-1:0]   pumpCurrentCode,
  output reg  [7:0]               pumpStepSel_q,
  output wire [`PAC_RES_W-1:0]    filterSeriesResCode,
  output reg  [3:0]               filterSeriesResSel_q,
  output wire [`PAC_CAP_W-1:0]    filterParCapCode,
  output reg  [3:0]               filterParCapSel_q,
  output wire                     secondPoleSelect,
  output wire                     lockCountAccuracy,
  output wire                     lockOverrideSelect,
  output wire                     manualOscChoice,
  output wire [`PAC_LOCK_W-1:0]   oscALockCode,
  output wire [`PAC_LOCK_W-1:0]   oscBLockCode,
  output wire                     synthOnlySelect,
  output reg                      firstOscForce_q,
  output reg                      secondOscForce_q,
  output reg  [`PAC_LOCK_W-1:0]   manualLockCode_q
);

  wire selFilt = (regAddr == `PAC_ADDR_FILT);
  wire selMode = (regAddr == `PAC_ADDR_MODE);
  wire selOscA = (regAddr == `PAC_ADDR_OSCA);
  wire selOscB = (regAddr == `PAC_ADDR_OSCB);
  wire selAny  = selFilt | selMode | selOscA | selOscB;

  wire wrFilt = regWrEn & selFilt;
  wire wrMode = regWrEn & selMode;
  wire wrOscA = regWrEn & selOscA;
  wire wrOscB = regWrEn & selOscB;

  // Field storage
  pac_field #(.W(`PAC_PUMP_W), .RST(`PAC_PUMP_RST)) uPump (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrEn    (wrFilt),
    .wrData  (regWrData[`PAC_PUMP_MSB:`PAC_PUMP_LSB]),
    .value_q (pumpCurrentCode)
  );

  pac_field #(.W(`PAC_RES_W), .RST(`PAC_RES_RST)) uRes (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrEn    (wrFilt),
    .wrData  (regWrData[`PAC_RES_MSB:`PAC_RES_LSB]),
    .value_q (filterSeriesResCode)
  );

  pac_field #(.W(`PAC_CAP_W), .RST(`PAC_CAP_RST)) uCap (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrEn    (wrFilt),
    .wrData  (regWrData[`PAC_CAP_MSB:`PAC_CAP_LSB]),
    .value_q (filterParCapCode)
  );

  pac_field #(.W(1), .RST(`PAC_POLE_RST)) uPole (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrEn    (wrFilt),
    .wrData  (regWrData[`PAC_POLE_BIT]),
    .value_q (secondPoleSelect)
  );

  pac_field #(.W(1), .RST(`PAC_LCNT_RST)) uLcnt (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrEn    (wrMode),
    .wrData  (regWrData[`PAC_LCNT_BIT]),
    .value_q (lockCountAccuracy)
  );

  pac_field #(.W(1), .RST(`PAC_OVR_RST)) uOvr (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrEn    (wrMode),
    .wrData  (regWrData[`PAC_OVR_BIT]),
    .value_q (lockOverrideSelect)
  );

  pac_field #(.W(1), .RST(`PAC_SYN_RST)) uSyn (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrEn    (wrMode),
    .wrData  (regWrData[`PAC_SYN_BIT]),
    .value_q (synthOnlySelect)
  );

  pac_field #(.W(1), .RST(`PAC_CHOICE_RST)) uChoice (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrEn    (wrOscA),
    .wrData  (regWrData[`PAC_CHOICE_BIT]),
    .value_q (manualOscChoice)
  );

  pac_field #(.W(`PAC_LOCK_W), .RST(`PAC_OSCA_RST)) uOscA (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrEn    (wrOscA),
    .wrData  (regWrData[`PAC_LOCK_MSB:`PAC_LOCK_LSB]),
    .value_q (oscALockCode)
  );

  pac_field #(.W(`PAC_LOCK_W), .RST(`PAC_OSCB_RST)) uOscB (
    .clk     (clk),
    .rst_n   (rst_n),
    .wrEn    (wrOscB),
    .wrData  (regWrData[`PAC_LOCK_MSB:`PAC_LOCK_LSB]),
    .value_q (oscBLockCode)
  );

  // Read word assembly; reserved positions return zero
  reg [7:0] rdWord;
  always @* begin
    rdWord = `PAC_ZERO8;
    if (selFilt) begin
      rdWord[`PAC_PUMP_MSB:`PAC_PUMP_LSB] = pumpCurrentCode;
      rdWord[`PAC_RES_MSB:`PAC_RES_LSB]   = filterSeriesResCode;
      rdWord[`PAC_CAP_MSB:`PAC_CAP_LSB]   = filterParCapCode;
      rdWord[`PAC_POLE_BIT]               = secondPoleSelect;
    end else if (selMode) begin
      rdWord[`PAC_SYN_BIT]  = synthOnlySelect;
      rdWord[`PAC_LCNT_BIT] = lockCountAccuracy;
      rdWord[`PAC_OVR_BIT]  = lockOverrideSelect;
    end else if (selOscA) begin
      rdWord[`PAC_CHOICE_BIT]               = manualOscChoice;
      rdWord[`PAC_LOCK_MSB:`PAC_LOCK_LSB]   = oscALockCode;
    end else if (selOscB) begin
      rdWord[`PAC_LOCK_MSB:`PAC_LOCK_LSB]   = oscBLockCode;
    end
  end

  // Nonzero data written into reserved positions
  reg [7:0] rsvdMask;
  always @* begin
    rsvdMask = `PAC_ZERO8;
    if (selFilt) begin
      rsvdMask = `PAC_RSVD_FILT;
    end else if (selMode) begin
      rsvdMask = `PAC_RSVD_MODE;
    end else if (selOscA) begin
      rsvdMask = `PAC_RSVD_OSCA;
    end else if (selOscB) begin
      rsvdMask = `PAC_RSVD_OSCB;
    end
  end
  wire rsvdViol = regWrEn & selAny & (|(regWrData & rsvdMask));

  // Read port, one cycle latency
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData_q  <= `PAC_ZERO8;
      regRdValid_q <= 1'h0;
      regHit_q     <= 1'h0;
    end else begin
      regRdValid_q <= regRdEn;
      regHit_q     <= (regRdEn | regWrEn) & selAny;
      if (regRdEn) begin
        regRdData_q <= rdWord;
      end
    end
  end

  // Sticky flag, a new violation wins over a clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsvdErr_q <= 1'h0;
    end else if (rsvdViol) begin
      rsvdErr_q <= 1'h1;
    end else if (rsvdErrClr) begin
      rsvdErr_q <= 1'h0;
    end
  end

  // Decoded selections toward the analog loop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pumpStepSel_q        <= `PAC_PUMP_OH_RST;
      filterSeriesResSel_q <= `PAC_RES_OH_RST;
      filterParCapSel_q    <= `PAC_CAP_OH_RST;
      firstOscForce_q      <= 1'h0;
      secondOscForce_q     <= 1'h0;
      manualLockCode_q     <= `PAC_OSCA_RST;
    end else begin
      pumpStepSel_q        <= `PAC_ONE8 << pumpCurrentCode;
      filterSeriesResSel_q <= `PAC_ONE4 << filterSeriesResCode;
      filterParCapSel_q    <= `PAC_ONE4 << filterParCapCode;
      firstOscForce_q      <= lockOverrideSelect & manualOscChoice;
      secondOscForce_q     <= lockOverrideSelect & ~manualOscChoice;
      manualLockCode_q     <= manualOscChoice ? oscALockCode : oscBLockCode;
    end
  end

endmodule // pac_regs

`default_nettype wire

/* File: pac_regs_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module pac_regs_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] regAddr,
  input wire logic        regWrEn,
  input wire logic [7:0]  regWrData,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData_q,
  input wire logic        regRdValid_q,
  input wire logic        regHit_q,
  input wire logic        rsvdErr_q,
  input wire logic [2:0]  pumpCurrentCode,
  input wire logic [7:0]  pumpStepSel_q,
  input wire logic        manualOscChoice,
  input wire logic [4:0]  oscALockCode,
  input wire logic [4:0]  oscBLockCode,
  input wire logic [4:0]  manualLockCode_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_rd_valid: assert property (regRdEn |=> regRdValid_q)
    else $error("read valid missing");
  chk_valid_once: assert property (!regRdEn |=> !regRdValid_q)
    else $error("read valid without read");
  chk_pump_write: assert property (regWrEn && regAddr == 16'h00B0
    |=> pumpCurrentCode == ($past(regWrData) >> 5)) else $error("pump code not written");
  chk_pump_step: assert property (pumpStepSel_q == (8'h01 << $past(pumpCurrentCode)))
    else $error("pump step select wrong");
  chk_lock_mux: assert property (manualLockCode_q ==
    ($past(manualOscChoice) ? $past(oscALockCode) : $past(oscBLockCode)))
    else $error("manual lock code wrong");
  chk_unmapped_read: assert property (regRdEn && regAddr[15:2] != 14'h002C
    |=> regRdValid_q && !regHit_q && regRdData_q == 8'h00) else $error("unmapped read");
  chk_mapped_hit: assert property ((regRdEn || regWrEn) && regAddr[15:2] == 14'h002C
    |=> regHit_q) else $error("bank hit missing");
  chk_rsvd_flag: assert property (regWrEn && regAddr == 16'h00B1 && |(regWrData & 8'hF4)
    |=> rsvdErr_q) else $error("reserved write not flagged");

  cover property (regRdValid_q && regHit_q);
  cover property (rsvdErr_q);
  cover property (regRdValid_q && !regHit_q);
endmodule // pac_regs_checker

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [15:0] regAddr = 16'h0000;
  logic        regWrEn = 1'h0;
  logic        regRdEn = 1'h0;
  logic        rsvdErrClr = 1'h0;
  logic [7:0]  regWrData = 8'h00;
  wire  [7:0]  regRdData_q, pumpStepSel_q;
  wire  [3:0]  filterSeriesResSel_q, filterParCapSel_q;
  wire  [4:0]  oscALockCode, oscBLockCode, manualLockCode_q;
  wire  [2:0]  pumpCurrentCode;
  wire  [1:0]  filterSeriesResCode, filterParCapCode;
  wire         regRdValid_q, regHit_q, rsvdErr_q, lockCountAccuracy, lockOverrideSelect;
  wire         manualOscChoice, synthOnlySelect, firstOscForce_q, secondOscForce_q;
  wire         secondPoleSelect;
  int          errTotal = 0;
  int          numChecks = 0;
  int          cyc = 0;

  pac_regs dut_u (.clk, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdEn, .rsvdErrClr,
    .regRdData_q, .regRdValid_q, .regHit_q, .rsvdErr_q, .pumpCurrentCode, .pumpStepSel_q,
    .filterSeriesResCode, .filterSeriesResSel_q, .filterParCapCode, .filterParCapSel_q,
    .secondPoleSelect, .lockCountAccuracy, .lockOverrideSelect, .manualOscChoice,
    .oscALockCode, .oscBLockCode, .synthOnlySelect, .firstOscForce_q, .secondOscForce_q,
    .manualLockCode_q);

  initial begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errTotal = errTotal + 1;
      reportAndStop();
    end
  end

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    tick();
    regAddr = a;
    regWrData = d;
    regWrEn = 1'h1;
    tick();
    regWrEn = 1'h0;
  endtask

  // Read answers one cycle after the strobe edge
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
    tick();
    regAddr = a;
    regRdEn = 1'h1;
    tick();
    regRdEn = 1'h0;
    chk({6'h00, regRdValid_q, regHit_q}, {6'h00, 1'h1, h}, "valid hit");
    chk(regRdData_q, e, "read data");
  endtask

  task automatic t_defaults();
    rd(16'h00B0, 8'h8B, 1'h1);
    rd(16'h00B1, 8'h02, 1'h1);
    rd(16'h00B2, 8'h2B, 1'h1);
    rd(16'h00B3, 8'h00, 1'h1);
    chk(pumpStepSel_q, 8'h10, "pump step");
    chk({firstOscForce_q, secondOscForce_q, 1'h0, manualLockCode_q}, 8'h0B, "manual");
    $display("end defaults");
  endtask

  // Every pump code, with resistor, capacitor and pole codes cycling alongside
  task automatic t_codes();
    logic [7:0] d;
    for (int c = 0; c < 8; c++) begin
      d = {c[2:0], c[1:0], c[1:0], c[0]};
      wr(16'h00B0, d);
      chk({5'h00, pumpCurrentCode}, c[7:0], "pump code");
      chk({3'h0, filterSeriesResCode, filterParCapCode, secondPoleSelect},
        {3'h0, c[1:0], c[1:0], c[0]}, "filter codes");
      tick();
      chk(pumpStepSel_q, 8'h01 << c[2:0], "pump step");
      chk({filterSeriesResSel_q, filterParCapSel_q}, {2{4'h1 << c[1:0]}}, "filter");
      rd(16'h00B0, d, 1'h1);
    end
    $display("end codes");
  endtask

  task automatic t_mode_osc();
    // Synth only set; coarse lock count and manual lock override are set beside it
    wr(16'h00B1, 8'h0B);
    chk({5'h00, synthOnlySelect, lockCountAccuracy, lockOverrideSelect}, 8'h07, "mode");
    // Fine lock accuracy, as for a large external loop capacitor
    wr(16'h00B1, 8'h01);
    chk({5'h00, synthOnlySelect, lockCountAccuracy, lockOverrideSelect}, 8'h01, "mode");
    wr(16'h00B2, 8'h15);
    wr(16'h00B3, 8'h1F);
    chk({3'h0, oscBLockCode}, 8'h1F, "osc b code");
    tick();
    chk({firstOscForce_q, secondOscForce_q, 1'h0, manualLockCode_q}, 8'h5F, "osc b");
    wr(16'h00B2, 8'h35);
    chk({2'h0, manualOscChoice, oscALockCode}, 8'h35, "osc a code");
    tick();
    chk({firstOscForce_q, secondOscForce_q, 1'h0, manualLockCode_q}, 8'h95, "osc a");
    rd(16'h00B2, 8'h35, 1'h1);
    rd(16'h00B3, 8'h1F, 1'h1);
    $display("end mode osc");
  endtask

  task automatic t_rsvd_reset();
    wr(16'h00B1, 8'hF5);
    chk({7'h00, rsvdErr_q}, 8'h01, "rsvd flag");
    rd(16'h00B1, 8'h01, 1'h1);
    rsvdErrClr = 1'h1;
    tick();
    rsvdErrClr = 1'h0;
    chk({7'h00, rsvdErr_q}, 8'h00, "rsvd clear");
    // A violation and a clear in one cycle: the violation wins
    tick();
    regAddr = 16'h00B3;
    regWrData = 8'hE0;
    regWrEn = 1'h1;
    rsvdErrClr = 1'h1;
    tick();
    regWrEn = 1'h0;
    rsvdErrClr = 1'h0;
    chk({7'h00, rsvdErr_q}, 8'h01, "rsvd set wins");
    wr(16'h01B0, 8'h00);
    rd(16'h00B4, 8'h00, 1'h0);
    rd(16'h00B0, 8'hFF, 1'h1);
    rst_n = 1'h0;
    tick();
    rst_n = 1'h1;
    chk({7'h00, rsvdErr_q}, 8'h00, "rsvd after reset");
    rd(16'h00B0, 8'h8B, 1'h1);
    $display("end rsvd reset");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'h1;
    t_defaults();
    t_codes();
    t_mode_osc();
    t_rsvd_reset();
    reportAndStop();
  end
endmodule // tb_top

bind pac_regs pac_regs_checker chk_u (.clk, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdEn,
  .regRdData_q, .regRdValid_q, .regHit_q, .rsvdErr_q, .pumpCurrentCode, .pumpStepSel_q,
  .manualOscChoice, .oscALockCode, .oscBLockCode, .manualLockCode_q);

`default_nettype wire
